// >>> logic/abe_arith.sv
// decimal adjust and unsigned divide datapath
`include "abe_defs.svh"

module abe_arith
(
    input  wire logic [7:0]        acc,
    input  wire logic [7:0]        divisor,
    input  wire logic              cy,
    input  wire logic              hc,
    output abe_pkg::abe_arith_t    res
);
    import abe_pkg::*;

    // restoring division; a zero divisor yields all-ones quotient
    function automatic logic [15:0] divide(input logic [7:0] n, input logic [7:0] d);
        logic [8:0] r;
        logic [7:0] q;
        r = 9'h000;
        q = n;
        for (int i = 0; i < 8; i++) begin
            r = {r[7:0], q[7]};
            q = {q[6:0], 1'b0};
            if (r >= {1'b0, d}) begin
                r = r - {1'b0, d};
                q[0] = 1'b1;
            end
        end
        return {q, r[7:0]};
    endfunction

    wire        lo_fix = (acc[3:0] > `ABE_BCD_DIG_MAX) || hc;
    wire [8:0]  lo_sum = {1'b0, acc} + (lo_fix ? {1'b0, `ABE_BCD_LO_ADJ} : 9'h000);
    wire        hi_fix = cy || lo_sum[8] || (lo_sum[7:4] > `ABE_BCD_DIG_MAX);
    wire [8:0]  hi_sum = {1'b0, lo_sum[7:0]} + (hi_fix ? {1'b0, `ABE_BCD_HI_ADJ} : 9'h000);
    wire [15:0] qr     = divide(acc, divisor);

    // carry only ever set here, never cleared
    assign res = '{hi_sum[7:0], cy | lo_sum[8] | hi_sum[8], qr[15:8], qr[7:0], divisor == 8'h00};

endmodule

// >>> logic/abe_decode.sv
// opcode classifier: operation, length and machine cycles
`include "abe_defs.svh"

module abe_decode
(
    input  wire logic [7:0]        opc,
    output abe_pkg::abe_info_t     info
);
    import abe_pkg::*;

    function automatic abe_info_t classify(input logic [7:0] c);
        abe_info_t r;
        r = '{OP_OTHER, `ABE_LEN_1, `ABE_CYC_1};
        if (c == `ABE_OPC_CMP_AD) r = '{OP_CMP_AD, `ABE_LEN_3, `ABE_CYC_2};
        else if (c == `ABE_OPC_CMP_AI) r = '{OP_CMP_AI, `ABE_LEN_3, `ABE_CYC_2};
        else if (c[7:3] == `ABE_OPC_CMP_R) r = '{OP_CMP_R, `ABE_LEN_3, `ABE_CYC_2};
        else if (c[7:1] == `ABE_OPC_CMP_I) r = '{OP_CMP_I, `ABE_LEN_3, `ABE_CYC_2};
        else if (c == `ABE_OPC_ZERO_A) r = '{OP_ZERO_A, `ABE_LEN_1, `ABE_CYC_1};
        else if (c == `ABE_OPC_ZERO_C) r = '{OP_ZERO_C, `ABE_LEN_1, `ABE_CYC_1};
        else if (c == `ABE_OPC_ZERO_BIT) r = '{OP_ZERO_BIT, `ABE_LEN_2, `ABE_CYC_1};
        else if (c == `ABE_OPC_INV_A) r = '{OP_INV_A, `ABE_LEN_1, `ABE_CYC_1};
        else if (c == `ABE_OPC_INV_C) r = '{OP_INV_C, `ABE_LEN_1, `ABE_CYC_1};
        else if (c == `ABE_OPC_INV_BIT) r = '{OP_INV_BIT, `ABE_LEN_2, `ABE_CYC_1};
        else if (c == `ABE_OPC_BCD) r = '{OP_BCD, `ABE_LEN_1, `ABE_CYC_1};
        else if (c == `ABE_OPC_SUB1_A) r = '{OP_SUB1_A, `ABE_LEN_1, `ABE_CYC_1};
        else if (c[7:3] == `ABE_OPC_SUB1_R) r = '{OP_SUB1_R, `ABE_LEN_1, `ABE_CYC_1};
        else if (c == `ABE_OPC_SUB1_D) r = '{OP_SUB1_D, `ABE_LEN_2, `ABE_CYC_1};
        else if (c[7:1] == `ABE_OPC_SUB1_I) r = '{OP_SUB1_I, `ABE_LEN_1, `ABE_CYC_1};
        else if (c == `ABE_OPC_DIVIDE) r = '{OP_DIVIDE, `ABE_LEN_1, `ABE_CYC_4};
        else if (c[7:3] == `ABE_OPC_CDB_R) r = '{OP_CDB_R, `ABE_LEN_2, `ABE_CYC_2};
        else if (c == `ABE_OPC_CDB_D) r = '{OP_CDB_D, `ABE_LEN_3, `ABE_CYC_2};
        return r;
    endfunction

    assign info = classify(opc);

endmodule

// >>> logic/abe_defs.svh
// constants of the arithmetic and branch execution unit
//
// Operation
// - compare-branch: pc plus three, offset if unequal
// - compare-branch: carry on unsigned less, operands kept
// - compare pairs: acc/direct, acc/imm, reg/imm, indirect/imm
// - zero acc: all bits 0, flags kept
// - zero carry or addressed bit, one cycle
// - invert acc: one's complement, flags kept
// - invert carry or addressed bit, one cycle
// - bit invert on port uses output latch
// - bcd adjust: add 06 if nibble big or half-carry
// - bcd adjust: add 60 if carry or high big
// - bcd adjust: one cycle, signed-wrap kept
// - subtract one wraps, no flags change
// - subtract one: acc, reg, direct, indirect forms
// - subtract/count-down on port uses output latch
// - divide: quotient acc, remainder b, four cycles
// - divide by zero: signed-wrap set, carry cleared
// - count-down: decrement, branch when result nonzero
// - count-down location: register or direct byte
`ifndef ABE_DEFS_SVH
`define ABE_DEFS_SVH

// ----------------------------------------
// opcodes (slices for register and indirect forms)
// ----------------------------------------
`define ABE_OPC_CMP_AD   8'hB5
`define ABE_OPC_CMP_AI   8'hB4
`define ABE_OPC_CMP_I    7'h5B
`define ABE_OPC_CMP_R    5'h17
`define ABE_OPC_ZERO_A   8'hE4
`define ABE_OPC_ZERO_C   8'hC3
`define ABE_OPC_ZERO_BIT 8'hC2
`define ABE_OPC_INV_A    8'hF4
`define ABE_OPC_INV_C    8'hB3
`define ABE_OPC_INV_BIT  8'hB2
`define ABE_OPC_BCD      8'hD4
`define ABE_OPC_SUB1_A   8'h14
`define ABE_OPC_SUB1_D   8'h15
`define ABE_OPC_SUB1_I   7'h0B
`define ABE_OPC_SUB1_R   5'h03
`define ABE_OPC_DIVIDE   8'h84
`define ABE_OPC_CDB_D    8'hD5
`define ABE_OPC_CDB_R    5'h1B

// ----------------------------------------
// lengths, machine cycles, clocks per cycle
// ----------------------------------------
`define ABE_LEN_1        2'h1
`define ABE_LEN_2        2'h2
`define ABE_LEN_3        2'h3
`define ABE_CYC_1        3'h1
`define ABE_CYC_2        3'h2
`define ABE_CYC_4        3'h4
`define ABE_MC_CLKS      5'h04

// ----------------------------------------
// special bytes, status bits, reset values
// ----------------------------------------
`define ABE_SFR_ACC      8'hE0
`define ABE_SFR_B        8'hF0
`define ABE_SFR_STS      8'hD0
`define ABE_SFR_PORT     8'h90
`define ABE_BIT_RAM_BASE 8'h20
`define ABE_ST_CY        7
`define ABE_ST_HC        6
`define ABE_ST_RS_HI     4
`define ABE_ST_RS_LO     3
`define ABE_ST_SW        2
`define ABE_RST_PC       16'h0000
`define ABE_RST_BYTE     8'h00
`define ABE_RST_PORT     8'hFF
`define ABE_BCD_LO_ADJ   8'h06
`define ABE_BCD_HI_ADJ   8'h60
`define ABE_BCD_DIG_MAX  4'h9

`endif

// >>> logic/abe_exec_unit.sv
// execution unit: compare-branch, zero, invert, bcd adjust, subtract, divide, count-down
`include "abe_defs.svh"

module abe_exec_unit
(
    input  wire logic         CLK,
    input  wire logic         NRST,
    output logic [15:0]       PM_ADDR,
    input  wire logic [7:0]   PM_DATA,
    input  wire logic [7:0]   PORT_PIN,
    output logic [7:0]        PORT_OUT,
    output logic [7:0]        ACC_OUT,
    output logic [7:0]        B_OUT,
    output logic [7:0]        STATUS_OUT,
    output logic [15:0]       PC_OUT,
    output logic              INSTR_DONE
);
    import abe_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    abe_st_t     st;
    abe_st_t     next_st;
    logic [3:0]  cnt;
    logic [15:0] pc;
    logic [15:0] fa;
    logic [7:0]  ir0;
    logic [7:0]  ir1;
    logic [7:0]  ir2;
    logic [7:0]  acc;
    logic [7:0]  b;
    logic [7:0]  sts;
    logic [7:0]  port_lat;
    logic [7:0]  pin_m;
    logic [7:0]  pin_s;
    logic [7:0]  iram [0:127];
    abe_info_t   info;
    abe_arith_t  ar;

    function automatic logic [7:0] wr_merge(input logic [7:0] cur, input logic go,
                                            input logic [7:0] addr, input logic [7:0] sfr,
                                            input logic [7:0] data);
        return (go && addr == sfr) ? data : cur;
    endfunction

    // bits 00-7F live in ram bytes 20-2F, others in byte-aligned specials
    function automatic logic [7:0] bit_home(input logic [7:0] ba);
        return ba[7] ? {ba[7:3], 3'h0} : (`ABE_BIT_RAM_BASE + {4'h0, ba[6:3]});
    endfunction

    abe_decode u_decode (
        .opc  (ir0),
        .info (info)
    );

    abe_arith u_arith (
        .acc     (acc),
        .divisor (b),
        .cy      (sts[`ABE_ST_CY]),
        .hc      (sts[`ABE_ST_HC]),
        .res     (ar)
    );

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    wire [4:0] span = 5'(info.ncyc * `ABE_MC_CLKS);
    wire [3:0] last = 4'(span - 5'h01);
    wire       done = (st != S_FETCH) && (cnt == last);
    wire       ex   = (st == S_EXEC);

    always_comb begin
        next_st = st;
        unique case (st)
            S_FETCH: begin
                if (cnt == 4'h2) next_st = S_EXEC;
            end
            S_EXEC: begin
                next_st = done ? S_FETCH : S_WAIT;
            end
            S_WAIT: begin
                if (done) next_st = S_FETCH;
            end
        endcase
    end

    // ----------------------------------------
    // operand selection
    // ----------------------------------------
    wire [1:0] rs      = sts[`ABE_ST_RS_HI:`ABE_ST_RS_LO];
    wire [6:0] reg_idx = {2'b00, rs, ir0[2:0]};
    wire [6:0] ptr_idx = {2'b00, rs, 2'b00, ir0[0]};
    wire [7:0] reg_val = iram[reg_idx];
    wire [7:0] ptr     = iram[ptr_idx];
    wire [7:0] ind_val = ptr[7] ? 8'h00 : iram[ptr[6:0]];
    wire       is_bit  = (info.op == OP_ZERO_BIT) || (info.op == OP_INV_BIT);
    wire [7:0] bit_adr = bit_home(ir1);
    wire [2:0] bit_pos = ir1[2:0];
    wire [7:0] rd_addr = is_bit ? bit_adr : ir1;
    // only the plain compare samples pins; modify paths use the latch
    wire       rmw     = (info.op != OP_CMP_AD);
    wire [7:0] rd_val  = !rd_addr[7] ? iram[rd_addr[6:0]] :
                         (rd_addr == `ABE_SFR_ACC)  ? acc :
                         (rd_addr == `ABE_SFR_B)    ? b :
                         (rd_addr == `ABE_SFR_STS)  ? sts :
                         (rd_addr == `ABE_SFR_PORT) ? (rmw ? port_lat : pin_s) : 8'h00;

    wire       cmp_a   = (info.op == OP_CMP_AD) || (info.op == OP_CMP_AI);
    wire [7:0] opa     = cmp_a ? acc : (info.op == OP_CMP_R) ? reg_val : ind_val;
    wire [7:0] opb     = (info.op == OP_CMP_AD) ? rd_val : ir1;
    wire       cmp_ne  = (opa != opb);
    wire       cmp_lt  = (opa < opb);
    wire       is_cmp  = cmp_a || (info.op == OP_CMP_R) || (info.op == OP_CMP_I);
    wire       is_cdb  = (info.op == OP_CDB_R) || (info.op == OP_CDB_D);

    // displacement is always the last byte, counted from the next instruction
    wire [7:0]  rel    = (info.nbytes == `ABE_LEN_3) ? ir2 : ir1;
    wire [15:0] seq_pc = pc + {14'h0000, info.nbytes};
    wire [15:0] br_pc  = seq_pc + {{8{rel[7]}}, rel};

    wire       tgt_r   = (info.op == OP_SUB1_R) || (info.op == OP_CDB_R);
    wire       tgt_d   = (info.op == OP_SUB1_D) || (info.op == OP_CDB_D);
    wire [7:0] tgt_val = (info.op == OP_SUB1_A) ? acc :
                         tgt_r ? reg_val :
                         tgt_d ? rd_val : ind_val;
    wire [7:0] tgt_adr = (info.op == OP_SUB1_A) ? `ABE_SFR_ACC :
                         tgt_r ? {1'b0, reg_idx} :
                         tgt_d ? ir1 : ptr;
    // no upper ram: indirect writes above 7F are dropped
    wire       tgt_ok  = !((info.op == OP_SUB1_I) && ptr[7]);
    wire [7:0] minus1  = tgt_val - 8'h01;
    wire [7:0] bit_msk = 8'h01 << bit_pos;
    wire [7:0] bit_new = (info.op == OP_ZERO_BIT) ? (rd_val & ~bit_msk) : (rd_val ^ bit_msk);

    // ----------------------------------------
    // execute
    // ----------------------------------------
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       cy_we;
    logic       cy_val;
    logic       ov_we;
    logic       ov_val;
    logic       div_we;
    logic       take;

    always_comb begin
        wr_en   = 1'b0;
        wr_addr = `ABE_SFR_ACC;
        wr_data = acc;
        cy_we   = 1'b0;
        cy_val  = 1'b0;
        ov_we   = 1'b0;
        ov_val  = 1'b0;
        div_we  = 1'b0;
        take    = 1'b0;
        unique case (info.op)
            OP_CMP_AD, OP_CMP_AI, OP_CMP_R, OP_CMP_I: begin
                take   = cmp_ne;
                cy_we  = 1'b1;
                cy_val = cmp_lt;
            end
            OP_ZERO_A: begin
                wr_en   = 1'b1;
                wr_data = 8'h00;
            end
            OP_INV_A: begin
                wr_en   = 1'b1;
                wr_data = ~acc;
            end
            OP_ZERO_C: begin
                cy_we = 1'b1;
            end
            OP_INV_C: begin
                cy_we  = 1'b1;
                cy_val = ~sts[`ABE_ST_CY];
            end
            OP_ZERO_BIT, OP_INV_BIT: begin
                wr_en   = 1'b1;
                wr_addr = bit_adr;
                wr_data = bit_new;
            end
            OP_BCD: begin
                wr_en   = 1'b1;
                wr_data = ar.bcd_val;
                cy_we   = 1'b1;
                cy_val  = ar.bcd_cy;
            end
            OP_SUB1_A, OP_SUB1_R, OP_SUB1_D, OP_SUB1_I: begin
                wr_en   = tgt_ok;
                wr_addr = tgt_adr;
                wr_data = minus1;
            end
            OP_CDB_R, OP_CDB_D: begin
                wr_en   = 1'b1;
                wr_addr = tgt_adr;
                wr_data = minus1;
                take    = (minus1 != 8'h00);
            end
            OP_DIVIDE: begin
                div_we = 1'b1;
                cy_we  = 1'b1;
                ov_we  = 1'b1;
                ov_val = ar.div_zero;
            end
            OP_OTHER: begin
                take = 1'b0;
            end
        endcase
    end

    wire        wr_go    = ex && wr_en;
    wire [7:0]  sts_w    = wr_merge(sts, wr_go, wr_addr, `ABE_SFR_STS, wr_data);
    wire [7:0]  next_acc = (ex && div_we) ? ar.quo : wr_merge(acc, wr_go, wr_addr, `ABE_SFR_ACC, wr_data);
    wire [7:0]  next_b   = (ex && div_we) ? ar.rem : wr_merge(b, wr_go, wr_addr, `ABE_SFR_B, wr_data);
    wire [7:0]  next_prt = wr_merge(port_lat, wr_go, wr_addr, `ABE_SFR_PORT, wr_data);
    wire [15:0] next_pc  = take ? br_pc : seq_pc;
    logic [7:0] next_sts;

    always_comb begin
        next_sts = sts_w;
        if (ex && cy_we) next_sts[`ABE_ST_CY] = cy_val;
        if (ex && ov_we) next_sts[`ABE_ST_SW] = ov_val;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st  <= S_FETCH;
            cnt <= 4'h0;
        end else begin
            st  <= next_st;
            cnt <= done ? 4'h0 : cnt + 4'h1;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ir0 <= `ABE_RST_BYTE;
            ir1 <= `ABE_RST_BYTE;
            ir2 <= `ABE_RST_BYTE;
        end else if (st == S_FETCH) begin
            if (cnt == 4'h0) ir0 <= PM_DATA;
            if (cnt == 4'h1) ir1 <= PM_DATA;
            if (cnt == 4'h2) ir2 <= PM_DATA;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pc <= `ABE_RST_PC;
            fa <= `ABE_RST_PC;
        end else if (st == S_FETCH) begin
            fa <= fa + 16'h0001;
        end else if (ex) begin
            pc <= next_pc;
            fa <= next_pc;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            acc      <= `ABE_RST_BYTE;
            b        <= `ABE_RST_BYTE;
            sts      <= `ABE_RST_BYTE;
            port_lat <= `ABE_RST_PORT;
        end else begin
            acc      <= next_acc;
            b        <= next_b;
            sts      <= next_sts;
            port_lat <= next_prt;
        end
    end

    // ram carries no reset, as software initialises it
    always_ff @(posedge CLK) begin
        if (wr_go && !wr_addr[7]) iram[wr_addr[6:0]] <= wr_data;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_m <= 8'h00;
            pin_s <= 8'h00;
        end else begin
            pin_m <= PORT_PIN;
            pin_s <= pin_m;
        end
    end

    assign PM_ADDR    = fa;
    assign PORT_OUT   = port_lat;
    assign ACC_OUT    = acc;
    assign B_OUT      = b;
    assign STATUS_OUT = sts;
    assign PC_OUT     = pc;
    assign INSTR_DONE = done;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_two_cycles;
        (!INSTR_DONE) [*4] ##1 INSTR_DONE;
    endsequence

    sequence s_four_cycles;
        (!INSTR_DONE) [*8] ##5 INSTR_DONE;
    endsequence

    AST_CMP_SEQ: assert property (ex && is_cmp && !cmp_ne |=> pc == $past(pc) + 16'h0003)
        else $error("compare fell through to wrong address");
    AST_CMP_TAKEN: assert property (ex && is_cmp && cmp_ne |=> pc == $past(br_pc))
        else $error("compare branch target wrong");
    AST_CMP_TIME: assert property (ex && is_cmp |-> s_two_cycles)
        else $error("compare did not take two machine cycles");
    AST_CMP_CY: assert property (ex && is_cmp |=> sts[`ABE_ST_CY] == $past(cmp_lt) && $stable(acc))
        else $error("compare carry wrong or operand changed");
    AST_CMP_IND: assert property (ex && info.op == OP_CMP_I |=>
                                  sts[`ABE_ST_CY] == ($past(ind_val) < $past(ir1)))
        else $error("indirect compare used wrong operands");
    AST_ZERO_A: assert property (ex && info.op == OP_ZERO_A |=> acc == 8'h00 && $stable(sts))
        else $error("accumulator zero failed");
    AST_ZERO_C: assert property (ex && info.op == OP_ZERO_C |-> INSTR_DONE ##1 !sts[`ABE_ST_CY])
        else $error("carry zero failed");
    AST_INV_A: assert property (ex && info.op == OP_INV_A |=> acc == ~$past(acc) && $stable(sts))
        else $error("accumulator invert failed");
    AST_INV_C: assert property (ex && info.op == OP_INV_C |=>
                                sts[`ABE_ST_CY] != $past(sts[`ABE_ST_CY]) && $stable(acc))
        else $error("carry invert failed");
    AST_INV_PORT: assert property (ex && info.op == OP_INV_BIT && bit_adr == `ABE_SFR_PORT |=>
                                   port_lat == ($past(port_lat) ^ $past(bit_msk)))
        else $error("port bit invert not based on latch");
    AST_BCD_CY: assert property (ex && info.op == OP_BCD && sts[`ABE_ST_CY] |=> sts[`ABE_ST_CY])
        else $error("bcd adjust cleared carry");
    AST_BCD_VAL: assert property (ex && info.op == OP_BCD |=>
                                  (8'(acc - $past(acc)) inside {8'h00, 8'h06, 8'h60, 8'h66}))
        else $error("bcd correction outside allowed set");
    AST_BCD_OV: assert property (ex && info.op == OP_BCD |-> INSTR_DONE ##1 $stable(sts[`ABE_ST_SW]))
        else $error("bcd adjust touched signed-wrap or took too long");
    AST_SUB1_A: assert property (ex && info.op == OP_SUB1_A |=>
                                 acc == 8'($past(acc) - 8'h01) && $stable(sts))
        else $error("accumulator subtract wrong");
    AST_SUB1_R: assert property (ex && info.op == OP_SUB1_R |-> INSTR_DONE ##1
                                 iram[$past(reg_idx)] == 8'($past(reg_val) - 8'h01))
        else $error("register subtract wrong");
    AST_SUB1_PORT: assert property (ex && tgt_d && ir1 == `ABE_SFR_PORT |=>
                                    port_lat == 8'($past(port_lat) - 8'h01))
        else $error("port decrement not based on latch");
    AST_DIV_RES: assert property (ex && info.op == OP_DIVIDE && b != 8'h00 |=>
                                  acc == $past(acc) / $past(b) && b == $past(acc) % $past(b) &&
                                  !sts[`ABE_ST_CY] && !sts[`ABE_ST_SW])
        else $error("divide result or flags wrong");
    AST_DIV_ZERO: assert property (ex && info.op == OP_DIVIDE && b == 8'h00 |=>
                                   sts[`ABE_ST_SW] && !sts[`ABE_ST_CY])
        else $error("divide by zero flags wrong");
    AST_DIV_TIME: assert property (ex && info.op == OP_DIVIDE |-> s_four_cycles)
        else $error("divide did not take four machine cycles");
    AST_CDB_BR: assert property (ex && is_cdb |=>
                                 pc == (($past(minus1) != 8'h00) ? $past(br_pc) : $past(seq_pc)))
        else $error("count-down branch decision wrong");
    AST_CDB_LEN: assert property (ex && info.op == OP_CDB_D && !take |=> pc == $past(pc) + 16'h0003)
        else $error("count-down direct form fell through to wrong address");

endmodule

// >>> logic/abe_pkg.sv
// types shared by the execution unit and its helpers
package abe_pkg;

    typedef enum logic [4:0] {
        OP_OTHER, OP_CMP_AD, OP_CMP_AI, OP_CMP_R, OP_CMP_I,
        OP_ZERO_A, OP_ZERO_C, OP_ZERO_BIT, OP_INV_A, OP_INV_C,
        OP_INV_BIT, OP_BCD, OP_SUB1_A, OP_SUB1_R, OP_SUB1_D,
        OP_SUB1_I, OP_DIVIDE, OP_CDB_R, OP_CDB_D
    } abe_op_t;

    typedef enum logic [1:0] {S_FETCH, S_EXEC, S_WAIT} abe_st_t;

    typedef struct packed {
        abe_op_t    op;
        logic [1:0] nbytes;
        logic [2:0] ncyc;
    } abe_info_t;

    typedef struct packed {
        logic [7:0] bcd_val;
        logic       bcd_cy;
        logic [7:0] quo;
        logic [7:0] rem;
        logic       div_zero;
    } abe_arith_t;

endpackage

// >>> sim/abe_exec_unit_bench.sv
// self-checking bench for the execution unit
module abe_exec_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] pm_addr, pc;
    logic [7:0]  pm_data, port, acc, b, sts;
    logic [7:0]  pins = 8'h00;
    logic        done;
    int          n_errors = 0;
    int          num_checks = 0;
    int          lt;

    always #2.5 clk = ~clk;

    abe_exec_unit dut (.CLK(clk), .NRST(nrst), .PM_ADDR(pm_addr), .PM_DATA(pm_data),
        .PORT_PIN(pins), .PORT_OUT(port), .ACC_OUT(acc), .B_OUT(b),
        .STATUS_OUT(sts), .PC_OUT(pc), .INSTR_DONE(done));
    abe_rom rom (.addr(pm_addr), .data(pm_data));

    task summarize;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // load program, restart from address 0
    task run(input logic [63:0] w);
        for (int i = 0; i < 256; i++)
            rom.mem[i] = (i < 8) ? w[63-8*i -: 8] : 8'h00;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
    endtask

    // wait k instructions; lt counts clocks of the last one
    task step(input int k);
        for (int j = 0; j < k; j++) begin
            lt = 0;
            do begin
                @(negedge clk);
                lt++;
            end while (done !== 1'b1 && lt < 40);
            if (done !== 1'b1) begin
                chk(16'(done), 16'h0001);
                summarize();
            end
        end
        @(posedge clk);
        #1;
    endtask

    task t_acc;
        run(64'hB3F414F4_E4140000);
        step(4);
        chk(16'(acc), 16'h0001);
        step(2);
        chk(16'(acc), 16'h00FF);
        chk(16'(sts), 16'h0080);
        chk(16'(lt), 16'h0004);
        run(64'hB3C30000_00000000);
        step(1);
        chk(16'(sts), 16'h0080);
        step(1);
        chk(16'(sts), 16'h0000);
    endtask

    task t_bcd;
        run(64'h84D4D400_00000000);
        step(2);
        chk(16'(acc), 16'h0065);
        chk(16'(sts), 16'h0084);
        step(1);
        chk(16'(acc), 16'h00C5);
        chk(16'(sts), 16'h0084);
        chk(16'(lt), 16'h0004);
    endtask

    task t_div;
        run(64'hB315F0F4_84B38400);
        step(4);
        chk({acc, b}, 16'h0100);
        chk(16'(sts), 16'h0000);
        chk(16'(lt), 16'h0010);
        step(2);
        chk(16'(sts), 16'h0004);
    endtask

    task t_cmp;
        run(64'hB4051000_00000000);
        step(1);
        chk(pc, 16'h0013);
        chk({acc, sts}, 16'h0080);
        chk(16'(lt), 16'h0008);
        chk(pm_addr, 16'h0013);
        run(64'hB4000500_00000000);
        step(1);
        chk({pc[7:0], sts}, 16'h0300);
        @(posedge clk) pins <= 8'h01;
        run(64'hF4B59002_00000000);
        step(2);
        chk({pc[7:0], sts}, 16'h0600);
    endtask

    // registers and indirect target preloaded, ram has no reset
    task t_reg;
        dut.iram[0] = 8'h56;
        dut.iram[1] = 8'h40;
        dut.iram[64] = 8'h05;
        run(64'hB86000B7_05001719);
        step(1);
        chk(16'(sts), 16'h0080);
        step(1);
        chk({pc[7:0], sts}, 16'h0600);
        step(1);
        chk(16'(dut.iram[64]), 16'h0004);
        step(1);
        chk(16'(dut.iram[1]), 16'h003F);
    endtask

    task t_cdb;
        run(64'hD5E0FD00_00000000);
        step(1);
        chk({pc[7:0], acc}, 16'h00FF);
        run(64'hF414F4D5_E0FD0000);
        step(4);
        chk({pc[7:0], acc}, 16'h0600);
    endtask

    task t_port;
        run(64'h1590B297_C2910000);
        step(1);
        chk(16'(port), 16'h00FE);
        step(1);
        chk(16'(port), 16'h007E);
        step(1);
        chk(16'(port), 16'h007C);
    endtask

    initial begin
        t_acc();
        t_bcd();
        t_div();
        t_cmp();
        t_cdb();
        t_port();
        t_reg();
        summarize();
    end
endmodule

// >>> sim/abe_rom.sv
// program memory model: asynchronous byte rom
module abe_rom (
    input  wire logic [15:0] addr,
    output logic [7:0]       data
);
    timeunit 1ns;
    timeprecision 1ps;
    // only 256 bytes, enough for the short test programs
    logic [7:0] mem [0:255];
    assign data = mem[addr[7:0]];
endmodule
